// ---- wdt_timer.sv ----
/*
 * wdt_timer: watchdog and interval timer with its AHB-Lite register slave,
 * feed sequence checker, chip reset sequencer and interrupt logic.
 * Assumes: the rc oscillator arrives as a tick level on a pin, the fuse,
 * other reset, power-down and oscillator-stable levels are asynchronous
 * pins; the bus has this block as its only slave.
 */

module wdt_timer (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // pins
    input wire logic DOG_ENABLE_FUSE,
    input wire logic RC_OSC_TICK,
    input wire logic OTHER_RESET,
    input wire logic POWER_DOWN,
    input wire logic OSC_STABLE,
    // chip reset and interrupt
    output logic CHIP_RESET,
    output logic OSC_RESTART,
    output logic IRQ
);
    import wdt_pkg::*;

    function automatic logic hit(input logic [9:0] idx, input logic [9:0] reg_idx);
        return idx == reg_idx;
    endfunction : hit

    // pin synchronisers
    logic [SY_W-1:0] in_raw;
    logic [SY_W-1:0] sync1_q;
    logic [SY_W-1:0] sync2_q;
    logic rc_prev_q;

    assign in_raw = {OSC_STABLE, POWER_DOWN, OTHER_RESET, RC_OSC_TICK, DOG_ENABLE_FUSE};

    genvar gi;
    generate
        for (gi = 0; gi < SY_W; gi++) begin : g_sync
            always_ff @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= in_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rc_prev_q <= 1'b0;
        end else begin
            rc_prev_q <= sync2_q[SY_RC];
        end
    end

    wire fuse = sync2_q[SY_FUSE];
    wire other_rst = sync2_q[SY_OTHER];
    wire pwr_down = sync2_q[SY_PD];
    wire osc_ok = sync2_q[SY_STABLE];
    wire rc_tick = sync2_q[SY_RC] & ~rc_prev_q;

    // bus slave: address phase capture
    logic wr_pend_q;
    logic rd_pend_q;
    logic [IDX_W-1:0] idx_q;
    logic [31:0] rdata_q;

    wire take = HSEL & HREADY & HTRANS[HTRANS_ACT];
    wire addr_ok = (HADDR[31:12] == 20'h0_0000) & (HADDR[1:0] == 2'h0);
    wire [IDX_W-1:0] addr_idx = addr_ok ? HADDR[11:2] : {IDX_W{1'b1}};

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q <= '0;
        end else begin
            wr_pend_q <= take & HWRITE;
            rd_pend_q <= take & ~HWRITE;
            if (take) begin
                idx_q <= addr_idx;
            end
        end
    end

    // reads take one wait state so data comes from a flop
    assign HREADYOUT = ~rd_pend_q;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_q;

    wire wr_ctl_bus = wr_pend_q & hit(idx_q, IDX_CONTROL);
    wire wr_feed = wr_pend_q & hit(idx_q, IDX_FEED);
    wire wr_clear = wr_pend_q & hit(idx_q, IDX_CLEAR);
    wire wr_enable = wr_pend_q & hit(idx_q, IDX_ENABLE);
    wire [7:0] wbyte = HWDATA[7:0];

    // control register state
    logic ovf_q;
    logic run_q;
    logic clk_q;
    logic [SEL_W-1:0] sel_q;
    logic lock_q;
    logic armed_q;
    logic [CNT_W-1:0] cnt_q;
    logic [DIV_W-1:0] div_q;
    logic [ST_W-1:0] st_q;
    logic [ST_W-1:0] en_q;
    wdt_rst_t rs_q;
    wdt_rst_t rs_d;
    logic [PULSE_W-1:0] pulse_q;

    wire run_eff = run_q | fuse;
    wire clk_eff = clk_q & ~fuse;
    wire [7:0] ctl_view = {2'b00, ovf_q, run_eff, clk_eff, sel_q};

    // write-once lock while the fuse is set
    wire wr_ctl = wr_ctl_bus & ~(fuse & lock_q);

    // feed sequence checker
    wire feed_ok = wr_feed & armed_q & (wbyte == FEED_SECOND);
    wire feed_arm = wr_feed & (wbyte == FEED_FIRST);
    wire feed_bad = wr_feed & ~feed_ok & ~feed_arm;

    // counter tick source; held while any reset is in effect
    wire div_tick = (div_q == DIV_W'(CPU_DIV - 1));
    wire src_tick = clk_eff ? div_tick : rc_tick;
    wire hold = other_rst | (rs_q != WDT_IDLE);
    wire cnt_tick = run_eff & ~hold & src_tick;
    wire [CNT_W-1:0] limit = CNT_W'(BASE_TICKS) << sel_q;
    wire overflow = cnt_tick & (cnt_q == limit - CNT_W'(1));
    wire dog_to = overflow & fuse;
    wire int_ovf = overflow & ~fuse;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            div_q <= '0;
        end else if (div_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cnt_q <= '0;
        end else if (hold | feed_ok | overflow) begin
            cnt_q <= '0;
        end else if (cnt_tick) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            armed_q <= 1'b0;
        end else if (other_rst | dog_to) begin
            armed_q <= 1'b0;
        end else if (wr_feed) begin
            armed_q <= feed_arm;
        end
    end

    // control register: reset loads follow the cause
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ovf_q <= CTL_RST_OFF[CTL_OVF];
            run_q <= CTL_RST_OFF[CTL_RUN];
            clk_q <= CTL_RST_OFF[CTL_CLK];
            sel_q <= CTL_RST_OFF[SEL_W-1:0];
            lock_q <= 1'b0;
        end else if (dog_to) begin
            ovf_q <= CTL_RST_DOG[CTL_OVF];
            run_q <= CTL_RST_DOG[CTL_RUN];
            clk_q <= CTL_RST_DOG[CTL_CLK];
            sel_q <= CTL_RST_DOG[SEL_W-1:0];
            lock_q <= 1'b0;
        end else if (other_rst) begin
            ovf_q <= CTL_RST_OFF[CTL_OVF];
            run_q <= CTL_RST_OFF[CTL_RUN];
            clk_q <= CTL_RST_OFF[CTL_CLK];
            sel_q <= CTL_RST_OFF[SEL_W-1:0];
            lock_q <= 1'b0;
        end else begin
            ovf_q <= int_ovf | (ovf_q & ~feed_ok);
            if (wr_ctl) begin
                run_q <= wbyte[CTL_RUN];
                clk_q <= wbyte[CTL_CLK];
                sel_q <= wbyte[SEL_W-1:0];
                lock_q <= fuse;
            end
        end
    end

    // chip reset sequencer
    always_comb begin
        rs_d = rs_q;
        case (rs_q)
            WDT_IDLE: begin
                if (dog_to) begin
                    rs_d = pwr_down ? WDT_WAKE : WDT_PULSE;
                end
            end
            WDT_PULSE: begin
                if (pulse_q == PULSE_W'(RST_PULSE_CYC - 1)) begin
                    rs_d = WDT_IDLE;
                end
            end
            WDT_WAKE: begin
                if (osc_ok) begin
                    rs_d = WDT_PULSE;
                end
            end
            default: begin
                rs_d = WDT_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rs_q <= WDT_IDLE;
        end else begin
            rs_q <= rs_d;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pulse_q <= '0;
        end else if (rs_q == WDT_PULSE) begin
            pulse_q <= pulse_q + PULSE_W'(1);
        end else begin
            pulse_q <= '0;
        end
    end

    assign CHIP_RESET = (rs_q != WDT_IDLE);
    assign OSC_RESTART = (rs_q == WDT_WAKE);

    // interrupt status, set wins over clear
    wire [ST_W-1:0] st_set = {dog_to, feed_bad, int_ovf};
    wire [ST_W-1:0] st_clr = wr_clear ? HWDATA[ST_W-1:0] : '0;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_q <= '0;
            en_q <= '0;
        end else begin
            st_q <= st_set | (st_q & ~st_clr);
            if (wr_enable) begin
                en_q <= HWDATA[ST_W-1:0];
            end
        end
    end

    assign IRQ = |(st_q & en_q);

    // read data mux
    wire [31:0] rd_mux =
        hit(idx_q, IDX_CONTROL) ? {24'h00_0000, ctl_view} :
        hit(idx_q, IDX_STATUS) ? {{(32-ST_W){1'b0}}, st_q} :
        hit(idx_q, IDX_ENABLE) ? {{(32-ST_W){1'b0}}, en_q} :
        32'h0000_0000;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_q <= '0;
        end else if (rd_pend_q) begin
            rdata_q <= rd_mux;
        end
    end

endmodule : wdt_timer

// ---- wdt_pkg.sv ----
/*
 * wdt_pkg: constants, register indexes, field positions and types of the
 * watchdog / interval timer.
 * Assumes one 100 MHz clock and an AHB-Lite bus with 32-bit data.
 */
package wdt_pkg;

    // clock and reset pulse timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RST_PULSE_NS = 1000;
    localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_W = 7;

    // counter clocking: cpu clock / 6 or rc oscillator ticks
    localparam int unsigned CPU_DIV = 6;
    localparam int unsigned DIV_W = 3;
    localparam int unsigned MIN_TIMEOUT_MS = 16;
    localparam int unsigned RC_TICK_US = 1000;
    localparam int unsigned BASE_TICKS = MIN_TIMEOUT_MS * 1000 / RC_TICK_US;
    localparam int unsigned CNT_W = 12;

    // register indexes, byte address is four times the index
    localparam int unsigned IDX_W = 10;
    localparam logic [9:0] IDX_CONTROL = 10'h0a7;
    localparam logic [9:0] IDX_FEED = 10'h0a8;
    localparam logic [9:0] IDX_STATUS = 10'h0b0;
    localparam logic [9:0] IDX_CLEAR = 10'h0b1;
    localparam logic [9:0] IDX_ENABLE = 10'h0b2;

    // control register fields
    localparam int unsigned CTL_OVF = 5;
    localparam int unsigned CTL_RUN = 4;
    localparam int unsigned CTL_CLK = 3;
    localparam int unsigned SEL_W = 3;
    localparam logic [7:0] CTL_RST_DOG = 8'h30;
    localparam logic [7:0] CTL_RST_ON = 8'h10;
    localparam logic [7:0] CTL_RST_OFF = 8'h00;

    // feed sequence bytes
    localparam logic [7:0] FEED_FIRST = 8'h1e;
    localparam logic [7:0] FEED_SECOND = 8'he1;

    // interrupt status bits
    localparam int unsigned ST_OVF = 0;
    localparam int unsigned ST_BADFEED = 1;
    localparam int unsigned ST_DOGRST = 2;
    localparam int unsigned ST_W = 3;

    // synchronised pin inputs
    localparam int unsigned SY_FUSE = 0;
    localparam int unsigned SY_RC = 1;
    localparam int unsigned SY_OTHER = 2;
    localparam int unsigned SY_PD = 3;
    localparam int unsigned SY_STABLE = 4;
    localparam int unsigned SY_W = 5;

    localparam int unsigned HTRANS_ACT = 1;

    typedef enum logic [1:0] {
        WDT_IDLE = 2'b00,
        WDT_PULSE = 2'b01,
        WDT_WAKE = 2'b11
    } wdt_rst_t;

endpackage : wdt_pkg

// ---- wdt_timer_props.sv ----
/* wdt_timer_props: port checker for wdt_timer, bound below.
   Assumes HREADY is fed back from HREADYOUT. */
module wdt_timer_props import wdt_pkg::*; (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // bus
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // pins
    input wire logic DOG_ENABLE_FUSE,
    input wire logic OTHER_RESET,
    input wire logic OSC_STABLE,
    input wire logic CHIP_RESET,
    input wire logic OSC_RESTART
);
    logic [7:0] hi_q;
    logic [7:0] hi_d;
    wire logic req;
    assign req = HSEL && HREADY && HTRANS[1];
    // cycles of reset pulse after oscillator wait
    assign hi_d = (CHIP_RESET && !OSC_RESTART) ? hi_q + 8'h01 : 8'h00;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            hi_q <= 8'h00;
        else
            hi_q <= hi_d;
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    pulse_width_a: assert property ($fell(CHIP_RESET) |-> hi_q == 8'(RST_PULSE_CYC))
        else $error("reset pulse width wrong");
    restart_hold_a: assert property (OSC_RESTART |-> CHIP_RESET)
        else $error("oscillator restart without reset");
    restart_wait_a: assert property ($fell(OSC_RESTART) |-> $past(OSC_STABLE, 2))
        else $error("restart released before stable");
    restart_end_a: assert property (OSC_STABLE [*3] ##0 OSC_RESTART |=> !OSC_RESTART)
        else $error("restart held after stable");
    fuse_only_a: assert property ($rose(CHIP_RESET) |-> $past(DOG_ENABLE_FUSE, 3))
        else $error("chip reset in interval mode");
    other_hold_a: assert property (OTHER_RESET [*4] |-> !$rose(CHIP_RESET))
        else $error("timeout during other reset");
    read_wait_a: assert property (req && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    write_ready_a: assert property (req && HWRITE |=> HREADYOUT && !HRESP)
        else $error("write response wrong");
endmodule : wdt_timer_props

bind wdt_timer wdt_timer_props wdt_timer_props_inst (.CLK(CLK), .RESET(RESET), .HSEL(HSEL),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .DOG_ENABLE_FUSE(DOG_ENABLE_FUSE), .OTHER_RESET(OTHER_RESET), .OSC_STABLE(OSC_STABLE),
    .CHIP_RESET(CHIP_RESET), .OSC_RESTART(OSC_RESTART));

// ---- wdt_timer_tb_top.sv ----
/* wdt_timer_tb_top: self-checking bench for wdt_timer.
   Assumes the bench is the only bus master; rc ticks every two cycles. */
module wdt_timer_tb_top import wdt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, RC_OSC_TICK = 1'b0;
    logic DOG_ENABLE_FUSE = 1'b0, OTHER_RESET = 1'b0, POWER_DOWN = 1'b0, OSC_STABLE = 1'b1;
    logic [31:0] HADDR = 32'h0000_0000, HWDATA = 32'h0000_0000, rd;
    logic [1:0] HTRANS = 2'h0;
    logic HREADYOUT, HRESP, CHIP_RESET, OSC_RESTART, IRQ, ok;
    logic [31:0] HRDATA;
    bit rc_on = 1'b1;
    int num_errors = 0, comparisons = 0, n;
    wdt_timer wdt_timer_inst (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DOG_ENABLE_FUSE(DOG_ENABLE_FUSE),
        .RC_OSC_TICK(RC_OSC_TICK), .OTHER_RESET(OTHER_RESET), .POWER_DOWN(POWER_DOWN),
        .OSC_STABLE(OSC_STABLE), .CHIP_RESET(CHIP_RESET), .OSC_RESTART(OSC_RESTART), .IRQ(IRQ));
    initial begin
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK) if (rc_on) RC_OSC_TICK <= ~RC_OSC_TICK;
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // ready judged just before the edge, away from the update race
    task edge_rdy;
        do begin
            @(negedge CLK);
            ok = HREADYOUT;
            rd = HRDATA;
            @(posedge CLK);
        end while (ok !== 1'b1);
    endtask : edge_rdy
    task bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= {20'h0_0000, idx, 2'h0};
        edge_rdy();
        HTRANS <= 2'h0;
        HWDATA <= {24'h00_0000, d};
        edge_rdy();
    endtask : bus
    task chk(input logic [9:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        cmp(rd, exp);
    endtask : chk
    task do_reset(input logic fuse);
        RESET <= 1'b1;
        DOG_ENABLE_FUSE <= fuse;
        repeat (4) @(posedge CLK);
        RESET <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask : do_reset
    task wait_sig(input logic irq, input logic val, input int lim);
        n = 0;
        do begin
            @(negedge CLK);
            n++;
        end while ((irq ? IRQ : CHIP_RESET) !== val && n < lim);
        @(posedge CLK);
    endtask : wait_sig
    task t_interval;
        do_reset(1'b0);
        chk(IDX_CONTROL, 32'h0000_0000);
        chk(10'h000, 32'h0000_0000);
        bus(1'b1, IDX_ENABLE, 8'h01);
        bus(1'b1, IDX_CONTROL, 8'h10);
        wait_sig(1'b1, 1'b1, 200);
        cmp(IRQ, 1'b1);
        chk(IDX_STATUS, 32'h0000_0001);
        bus(1'b1, IDX_ENABLE, 8'h00);
        chk(IDX_CONTROL, 32'h0000_0030);
        cmp({IRQ, CHIP_RESET}, 2'h0);
        bus(1'b1, IDX_CONTROL, 8'h00);
        bus(1'b1, IDX_FEED, FEED_FIRST);
        bus(1'b1, IDX_ENABLE, 8'h03);
        bus(1'b1, IDX_FEED, FEED_SECOND);
        chk(IDX_CONTROL, 32'h0000_0000);
        cmp(IRQ, 1'b1);
        bus(1'b1, IDX_CLEAR, 8'h01);
        // stopped counter must not overflow again
        repeat (40) @(posedge CLK);
        chk(IDX_STATUS, 32'h0000_0000);
        cmp(IRQ, 1'b0);
    endtask : t_interval
    task t_cpudiv;
        rc_on = 1'b0;
        bus(1'b1, IDX_CONTROL, 8'h18);
        wait_sig(1'b1, 1'b1, 300);
        cmp(32'(n >= 90 && n <= 104), 32'h0000_0001);
        rc_on = 1'b1;
    endtask : t_cpudiv
    task t_dog;
        do_reset(1'b1);
        chk(IDX_CONTROL, 32'h0000_0010);
        bus(1'b1, IDX_FEED, FEED_FIRST);
        bus(1'b1, IDX_FEED, FEED_SECOND);
        bus(1'b1, IDX_CONTROL, 8'h09);
        chk(IDX_CONTROL, 32'h0000_0011);
        bus(1'b1, IDX_CONTROL, 8'h02);
        chk(IDX_CONTROL, 32'h0000_0011);
        bus(1'b1, IDX_FEED, FEED_FIRST);
        bus(1'b1, IDX_FEED, FEED_SECOND);
        repeat (30) @(posedge CLK);
        bus(1'b1, IDX_FEED, FEED_FIRST);
        bus(1'b1, IDX_FEED, 8'h55);
        wait_sig(1'b0, 1'b1, 200);
        // bad pair late in the period must not restart the count
        cmp(32'(n >= 26 && n <= 36), 32'h0000_0001);
        wait_sig(1'b0, 1'b0, 300);
        cmp(n, RST_PULSE_CYC);
        chk(IDX_CONTROL, 32'h0000_0030);
        chk(IDX_STATUS, 32'h0000_0006);
    endtask : t_dog
    task t_other_pd;
        OTHER_RESET <= 1'b1;
        wait_sig(1'b0, 1'b1, 150);
        cmp(n, 150);
        chk(IDX_CONTROL, 32'h0000_0010);
        OTHER_RESET <= 1'b0;
        POWER_DOWN <= 1'b1;
        OSC_STABLE <= 1'b0;
        wait_sig(1'b0, 1'b1, 100);
        wait_sig(1'b0, 1'b0, 150);
        cmp({OSC_RESTART, 31'(n)}, 32'h8000_0096);
        OSC_STABLE <= 1'b1;
        POWER_DOWN <= 1'b0;
        wait_sig(1'b0, 1'b0, 130);
        cmp(32'(n >= 100 && n <= 108), 32'h0000_0001);
    endtask : t_other_pd
    task results;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    initial begin
        t_interval();
        t_cpudiv();
        t_dog();
        t_other_pd();
        results();
    end
    initial begin
        repeat (20000) @(posedge CLK);
        num_errors++;
        results();
    end
endmodule : wdt_timer_tb_top
